// ### src/lsd_manual_timer.sv
// manual integration timer: counts 10.9 us steps while run is high
// assumes run comes from logic on the same clock
`timescale 1ns/1ps
`include "lsd_regs.svh"
module lsd_manual_timer
    import lsd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic run,
    // elapsed steps
    output lsd_word_t count
);
    localparam logic [9:0] STEP_LAST = 10'(`LSD_TIMER_STEP_CYC - 1);

    logic run_reg, run_next;
    logic [9:0] pre_reg, pre_next;
    lsd_word_t count_reg, count_next;

    always_comb begin
        run_next = run;
        pre_next = pre_reg;
        count_next = count_reg;
        if (run && !run_reg) begin
            // a fresh integration starts from zero
            pre_next = 10'h000;
            count_next = 16'h0000;
        end else if (run) begin
            if (pre_reg == STEP_LAST) begin
                pre_next = 10'h000;
                // wraps past 714.3 ms, as the hardware does
                count_next = count_reg + 16'h0001;
            end else begin
                pre_next = pre_reg + 10'h001;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_reg <= 1'b0;
            pre_reg <= 10'h000;
            count_reg <= 16'h0000;
        end else begin
            run_reg <= run_next;
            pre_reg <= pre_next;
            count_reg <= count_next;
        end
    end

    assign count = count_reg;
endmodule : lsd_manual_timer

// ### src/lsd_pkg.sv
// types shared by the light sensor register bank
// assumes lsd_regs.svh is on the include path
package lsd_pkg;
    typedef logic [7:0] lsd_byte_t;
    typedef logic [4:0] lsd_addr_t;
    typedef logic [15:0] lsd_word_t;
    // transaction field of a command byte, in field order
    typedef enum logic [1:0] {
        LSD_TXN_BYTE,
        LSD_TXN_WORD,
        LSD_TXN_BLOCK,
        LSD_TXN_SPECIAL
    } lsd_txn_t;
endpackage : lsd_pkg

// ### src/lsd_reg_bank.sv
// interrupt, threshold, gain, id and data registers of the sensor
// assumes a serial-bus framer delivers bytes on clk and the adc core
// reports each finished conversion with a one-cycle pulse
`timescale 1ns/1ps
`include "lsd_regs.svh"
module lsd_reg_bank
    import lsd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // byte port from the bus framer
    input wire logic xfer_start,
    input wire logic wr_stb,
    input wire lsd_byte_t wr_byte,
    input wire logic rd_stb,
    output lsd_byte_t rd_byte,
    output logic rd_valid,
    // adc core
    input wire logic adc_enable,
    input wire logic conv_done,
    input wire lsd_word_t ch0_in,
    input wire lsd_word_t ch1_in,
    input wire logic manual_run,
    output logic adc_halt,
    output logic [2:0] gain_sel,
    // open-drain interrupt pin
    output logic irq_pin_out,
    output logic irq_pin_oe
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic lsd_addr_t cur_addr(lsd_addr_t p, lsd_addr_t i);
        cur_addr = p + i;
    endfunction : cur_addr

    function automatic logic out_of_window(lsd_word_t v, lsd_word_t lo,
                                           lsd_word_t hi);
        out_of_window = (v <= lo) || (v > hi);
    endfunction : out_of_window

    // ****************************************************************
    // state
    // ****************************************************************
    lsd_addr_t ptr_reg, ptr_next;
    lsd_addr_t idx_reg, idx_next;
    logic first_reg, first_next;
    lsd_byte_t irq_ctrl_reg, irq_ctrl_next;
    lsd_word_t low_th_reg, low_th_next;
    lsd_word_t high_th_reg, high_th_next;
    logic [2:0] gain_reg, gain_next;
    lsd_byte_t variant_reg, variant_next;
    lsd_word_t ch0_reg, ch0_next;
    lsd_word_t ch1_reg, ch1_next;
    lsd_byte_t shadow0_reg, shadow0_next;
    lsd_byte_t shadow1_reg, shadow1_next;
    lsd_byte_t rd_byte_reg, rd_byte_next;
    logic rd_valid_reg, rd_valid_next;
    logic [3:0] cnt_reg, cnt_next;
    logic pend_reg, pend_next;
    logic halt_reg, halt_next;
    logic oe_reg, oe_next;
    lsd_word_t timer_count;
    lsd_addr_t acc_addr;
    logic is_cmd, irq_clear, irq_set, conv_ok, oow;
    logic [3:0] persist;
    logic [4:0] cnt_inc;

    lsd_manual_timer lsd_manual_timer_i (
        .clk(clk),
        .reset(reset),
        .run(manual_run),
        .count(timer_count)
    );

    // ****************************************************************
    // host access and registers
    // ****************************************************************
    assign acc_addr = cur_addr(ptr_reg, idx_reg);
    // a byte that collides with a restart is dropped, clear included
    assign is_cmd = wr_stb && first_reg && !xfer_start &&
        wr_byte[`LSD_CMD_BIT];
    assign irq_clear = is_cmd &&
        (lsd_txn_t'(wr_byte[`LSD_TXN_HI:`LSD_TXN_LO]) == LSD_TXN_SPECIAL);

    always_comb begin
        ptr_next = ptr_reg;
        idx_next = idx_reg;
        first_next = first_reg;
        irq_ctrl_next = irq_ctrl_reg;
        low_th_next = low_th_reg;
        high_th_next = high_th_reg;
        gain_next = gain_reg;
        variant_next = variant_reg;
        if (xfer_start) begin
            first_next = 1'b1;
            idx_next = 5'h00;
        end else if (is_cmd) begin
            ptr_next = wr_byte[`LSD_PTR_HI:0];
            idx_next = 5'h00;
            first_next = 1'b0;
        end else if (wr_stb) begin
            first_next = 1'b0;
            idx_next = idx_reg + 5'h01;
            unique case (acc_addr)
                `LSD_ADDR_IRQ_CTRL: irq_ctrl_next = wr_byte;
                `LSD_ADDR_LOW_TH_LSB: low_th_next[7:0] = wr_byte;
                `LSD_ADDR_LOW_TH_MSB: low_th_next[15:8] = wr_byte;
                `LSD_ADDR_HIGH_TH_LSB: high_th_next[7:0] = wr_byte;
                `LSD_ADDR_HIGH_TH_MSB: high_th_next[15:8] = wr_byte;
                `LSD_ADDR_ANALOG: gain_next = wr_byte[`LSD_GAIN_HI:0];
                `LSD_ADDR_VARIANT: variant_next = wr_byte;
                default: ;
            endcase
        end else if (rd_stb) begin
            first_next = 1'b0;
            idx_next = idx_reg + 5'h01;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ptr_reg <= 5'h00;
            idx_reg <= 5'h00;
            first_reg <= 1'b0;
            irq_ctrl_reg <= `LSD_RST_BYTE;
            low_th_reg <= `LSD_RST_WORD;
            high_th_reg <= `LSD_RST_WORD;
            gain_reg <= 3'h0;
            variant_reg <= {2'h0, `LSD_VARIANT_CODE, 4'h0};
        end else begin
            ptr_reg <= ptr_next;
            idx_reg <= idx_next;
            first_reg <= first_next;
            irq_ctrl_reg <= irq_ctrl_next;
            low_th_reg <= low_th_next;
            high_th_reg <= high_th_next;
            gain_reg <= gain_next;
            variant_reg <= variant_next;
        end
    end

    // ****************************************************************
    // conversion data and read path
    // ****************************************************************
    always_comb begin
        ch0_next = ch0_reg;
        ch1_next = ch1_reg;
        shadow0_next = shadow0_reg;
        shadow1_next = shadow1_reg;
        rd_byte_next = rd_byte_reg;
        rd_valid_next = 1'b0;
        if (conv_ok) begin
            ch0_next = ch0_in;
            ch1_next = ch1_in;
        end
        if (rd_stb && !wr_stb) begin
            rd_valid_next = 1'b1;
            unique case (acc_addr)
                `LSD_ADDR_IRQ_CTRL: rd_byte_next = irq_ctrl_reg;
                `LSD_ADDR_LOW_TH_LSB: rd_byte_next = low_th_reg[7:0];
                `LSD_ADDR_LOW_TH_MSB: rd_byte_next = low_th_reg[15:8];
                `LSD_ADDR_HIGH_TH_LSB: rd_byte_next = high_th_reg[7:0];
                `LSD_ADDR_HIGH_TH_MSB: rd_byte_next = high_th_reg[15:8];
                `LSD_ADDR_ANALOG: rd_byte_next = {5'h00, gain_reg};
                `LSD_ADDR_PART_REV:
                    rd_byte_next = {`LSD_PART_CODE, `LSD_REV_CODE};
                `LSD_ADDR_CH0_LSB: begin
                    rd_byte_next = ch0_reg[7:0];
                    shadow0_next = ch0_reg[15:8];
                end
                `LSD_ADDR_CH0_MSB: rd_byte_next = shadow0_reg;
                `LSD_ADDR_CH1_LSB: begin
                    rd_byte_next = ch1_reg[7:0];
                    shadow1_next = ch1_reg[15:8];
                end
                `LSD_ADDR_CH1_MSB: rd_byte_next = shadow1_reg;
                `LSD_ADDR_TIMER_LSB: rd_byte_next = timer_count[7:0];
                `LSD_ADDR_TIMER_MSB: rd_byte_next = timer_count[15:8];
                `LSD_ADDR_VARIANT: rd_byte_next = variant_reg;
                default: rd_byte_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ch0_reg <= `LSD_RST_WORD;
            ch1_reg <= `LSD_RST_WORD;
            shadow0_reg <= `LSD_RST_BYTE;
            shadow1_reg <= `LSD_RST_BYTE;
            rd_byte_reg <= `LSD_RST_BYTE;
            rd_valid_reg <= 1'b0;
        end else begin
            ch0_reg <= ch0_next;
            ch1_reg <= ch1_next;
            shadow0_reg <= shadow0_next;
            shadow1_reg <= shadow1_next;
            rd_byte_reg <= rd_byte_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    // ****************************************************************
    // interrupt and halt
    // ****************************************************************
    // a halted adc may still pulse; such results are dropped
    assign conv_ok = conv_done && !halt_reg;
    assign persist = irq_ctrl_reg[`LSD_PERSIST_HI:0];
    assign oow = out_of_window(ch0_in, low_th_reg, high_th_reg);
    assign cnt_inc = {1'b0, cnt_reg} + 5'h01;

    always_comb begin
        cnt_next = cnt_reg;
        irq_set = 1'b0;
        halt_next = halt_reg;
        if (conv_ok) begin
            if (persist == 4'h0) begin
                irq_set = 1'b1;
            end else if (oow) begin
                if (cnt_reg != 4'hf) begin
                    cnt_next = cnt_inc[3:0];
                end
                irq_set = (cnt_inc >= {1'b0, persist});
            end else begin
                cnt_next = 4'h0;
            end
        end
        // set beats clear so an event in the clear cycle is kept
        pend_next = (pend_reg && !irq_clear) ||
            (irq_set && irq_ctrl_reg[`LSD_MODE_BIT]);
        oe_next = pend_next && irq_ctrl_next[`LSD_MODE_BIT];
        if (pend_reg && irq_ctrl_reg[`LSD_HALT_BIT]) begin
            halt_next = 1'b1;
        end else if (!adc_enable && !pend_reg) begin
            halt_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= 4'h0;
            pend_reg <= 1'b0;
            halt_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            pend_reg <= pend_next;
            halt_reg <= halt_next;
            oe_reg <= oe_next;
        end
    end

    // open-drain: level is always low, the enable does the signalling
    logic pin_out_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_out_reg <= 1'b0;
        end else begin
            pin_out_reg <= 1'b0;
        end
    end

    assign rd_byte = rd_byte_reg;
    assign rd_valid = rd_valid_reg;
    assign adc_halt = halt_reg;
    assign gain_sel = gain_reg;
    assign irq_pin_out = pin_out_reg;
    assign irq_pin_oe = oe_reg;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_conv_in;
        conv_ok && irq_ctrl_reg[`LSD_MODE_BIT] && !irq_clear;
    endsequence
    sequence s_rd_at(lsd_addr_t a);
        rd_stb && !wr_stb && acc_addr == a;
    endsequence

    a_irq_mode_off: assert property (
        !irq_ctrl_next[`LSD_MODE_BIT] |=> !irq_pin_oe)
        else $error("interrupt pin driven while disabled");
    a_every_conv: assert property (
        s_conv_in and (persist == 4'h0) |=> pend_reg &&
            (irq_pin_oe || !irq_ctrl_reg[`LSD_MODE_BIT]))
        else $error("every-cycle mode missed an interrupt");
    a_single_out: assert property (
        s_conv_in and (persist == 4'h1) and oow |=> pend_reg)
        else $error("single out-of-window result missed");
    a_persist_wait: assert property (
        conv_ok && !pend_reg && persist > 4'h1 && oow &&
        cnt_inc < {1'b0, persist} |=> !pend_reg)
        else $error("interrupt raised before persistence met");
    a_count_reset: assert property (
        conv_ok && persist != 4'h0 && !oow |=> cnt_reg == 4'h0)
        else $error("persistence count not reset in window");
    a_cmd_pointer: assert property (
        is_cmd && !xfer_start |=> ptr_reg == lsd_addr_t'($past(wr_byte)))
        else $error("command byte not stored as pointer");
    a_shadow_read: assert property (
        s_rd_at(`LSD_ADDR_CH0_MSB) |=> rd_valid &&
            rd_byte == $past(shadow0_reg))
        else $error("high byte read not from shadow");
    a_shadow_latch: assert property (
        s_rd_at(`LSD_ADDR_CH0_LSB) |=>
            shadow0_reg == lsd_byte_t'($past(ch0_reg) >> 8))
        else $error("low byte read did not latch shadow");
    a_id_const: assert property (
        s_rd_at(`LSD_ADDR_PART_REV) |=>
            rd_byte == {`LSD_PART_CODE, `LSD_REV_CODE})
        else $error("id register value wrong");
    a_irq_clear: assert property (
        irq_clear && !irq_set |=> !pend_reg)
        else $error("special command did not clear interrupt");
    a_halt_on_irq: assert property (
        pend_reg && irq_ctrl_reg[`LSD_HALT_BIT] |=> adc_halt)
        else $error("adc not halted on interrupt");
endmodule : lsd_reg_bank

// ### src/lsd_regs.svh
// register offsets, field positions, reset values and timing counts
// for the light sensor register bank; definitions only
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define LSD_ADDR_IRQ_CTRL 5'h02
`define LSD_ADDR_LOW_TH_LSB 5'h03
`define LSD_ADDR_LOW_TH_MSB 5'h04
`define LSD_ADDR_HIGH_TH_LSB 5'h05
`define LSD_ADDR_HIGH_TH_MSB 5'h06
`define LSD_ADDR_ANALOG 5'h07
`define LSD_ADDR_PART_REV 5'h12
`define LSD_ADDR_CH0_LSB 5'h14
`define LSD_ADDR_CH0_MSB 5'h15
`define LSD_ADDR_CH1_LSB 5'h16
`define LSD_ADDR_CH1_MSB 5'h17
`define LSD_ADDR_TIMER_LSB 5'h18
`define LSD_ADDR_TIMER_MSB 5'h19
`define LSD_ADDR_VARIANT 5'h1e

// ****************************************************************
// field positions
// ****************************************************************
`define LSD_CMD_BIT 7
`define LSD_TXN_HI 6
`define LSD_TXN_LO 5
`define LSD_PTR_HI 4
`define LSD_HALT_BIT 6
`define LSD_MODE_BIT 4
`define LSD_PERSIST_HI 3
`define LSD_GAIN_HI 2
`define LSD_VARIANT_HI 5
`define LSD_VARIANT_LO 4

// ****************************************************************
// reset values and identity (identity values are arbitrary)
// ****************************************************************
`define LSD_RST_BYTE 8'h00
`define LSD_RST_WORD 16'h0000
`define LSD_PART_CODE 4'h5
`define LSD_REV_CODE 4'h2
`define LSD_VARIANT_CODE 2'h1

// ****************************************************************
// timing
// ****************************************************************
`define LSD_CLK_PERIOD_NS 20
`define LSD_TIMER_STEP_NS 10900
`define LSD_TIMER_STEP_CYC (`LSD_TIMER_STEP_NS / `LSD_CLK_PERIOD_NS)

`endif

// ### test/lsd_host_model.sv
// host side of the register bank's byte port, one byte per wr or rd call
// assumes its tasks are called from a single bench process
`timescale 1ns/1ps
module lsd_host_model
    import lsd_pkg::*;
(
    // clock
    input wire logic clk,
    // byte port towards the register bank
    output logic xfer_start,
    output logic wr_stb,
    output lsd_byte_t wr_byte,
    output logic rd_stb,
    input wire lsd_byte_t rd_byte,
    input wire logic rd_valid
);
    initial begin
        xfer_start = 1'b0;
        wr_stb = 1'b0;
        wr_byte = 8'h00;
        rd_stb = 1'b0;
    end

    task start();
        @(posedge clk);
        xfer_start <= 1'b1;
        @(posedge clk);
        xfer_start <= 1'b0;
    endtask : start

    // data line is scrambled once released so stale bytes never match
    task wr(input lsd_byte_t b);
        @(posedge clk);
        wr_stb <= 1'b1;
        wr_byte <= b;
        @(posedge clk);
        wr_stb <= 1'b0;
        wr_byte <= ~b;
    endtask : wr

    // one byte at the current pointer per call; a channel's high byte comes from the shadow latched by its low byte read
    task rd(output lsd_byte_t b, output logic ok);
        @(posedge clk);
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        ok = rd_valid;
        b = rd_byte;
    endtask : rd

    // thresholds only ever go out as whole words, never as single bytes
    task wword(input lsd_addr_t a, input lsd_word_t w);
        start();
        wr({3'b100, a});
        wr(w[7:0]);
        wr(w[15:8]);
    endtask : wword
endmodule : lsd_host_model

// ### test/lsd_reg_bank_tb.sv
// self-checking bench for the light sensor register bank
// assumes lsd_regs.svh on the include path and the host model alongside
`timescale 1ns/1ps
`include "lsd_regs.svh"
module lsd_reg_bank_tb
    import lsd_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic xfer_start, wr_stb, rd_stb, rd_valid;
    lsd_byte_t wr_byte, rd_byte;
    logic adc_enable = 1'b1;
    logic conv_done = 1'b0;
    logic manual_run = 1'b0;
    lsd_word_t ch0_in = 16'h0000;
    lsd_word_t ch1_in = 16'h0000;
    logic adc_halt, irq_pin_out, irq_pin_oe;
    logic [2:0] gain_sel;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;

    lsd_reg_bank lsd_reg_bank_i (.clk(clk), .reset(reset),
        .xfer_start(xfer_start), .wr_stb(wr_stb), .wr_byte(wr_byte),
        .rd_stb(rd_stb), .rd_byte(rd_byte), .rd_valid(rd_valid),
        .adc_enable(adc_enable), .conv_done(conv_done), .ch0_in(ch0_in),
        .ch1_in(ch1_in), .manual_run(manual_run), .adc_halt(adc_halt),
        .gain_sel(gain_sel), .irq_pin_out(irq_pin_out),
        .irq_pin_oe(irq_pin_oe));
    lsd_host_model lsd_host_model_i (.clk(clk), .xfer_start(xfer_start),
        .wr_stb(wr_stb), .wr_byte(wr_byte), .rd_stb(rd_stb),
        .rd_byte(rd_byte), .rd_valid(rd_valid));

    always #10 clk = ~clk;

    // ceiling well above the manual timer run, the longest scenario
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    // ****************************************************************
    // compare and access helpers
    // ****************************************************************
    task cmp_byte(input lsd_byte_t got, input lsd_byte_t exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_byte

    task cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_bit

    task rd_chk(input lsd_byte_t e);
        lsd_byte_t b;
        logic ok;
        lsd_host_model_i.rd(b, ok);
        cmp_bit(ok, 1'b1);
        cmp_byte(b, e);
    endtask : rd_chk

    task point(input lsd_addr_t a);
        lsd_host_model_i.start();
        lsd_host_model_i.wr({3'b100, a});
        lsd_host_model_i.start();
    endtask : point

    task chk_rd(input lsd_addr_t a, input lsd_byte_t e);
        point(a);
        rd_chk(e);
    endtask : chk_rd

    task wreg(input lsd_addr_t a, input lsd_byte_t d);
        lsd_host_model_i.start();
        lsd_host_model_i.wr({3'b100, a});
        lsd_host_model_i.wr(d);
    endtask : wreg

    task clr();
        lsd_host_model_i.start();
        lsd_host_model_i.wr({3'b111, `LSD_ADDR_IRQ_CTRL});
        // let the clearing edge settle before anyone looks at the pin
        #1;
    endtask : clr

    // irq and data registers are settled on return
    task conv(input lsd_word_t c0, input lsd_word_t c1);
        @(posedge clk);
        conv_done <= 1'b1;
        ch0_in <= c0;
        ch1_in <= c1;
        @(posedge clk);
        conv_done <= 1'b0;
        ch0_in <= ~c0;
        ch1_in <= ~c1;
        #1;
    endtask : conv

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_reset();
        for (int i = 3; i < 8; i++) chk_rd(5'(i), `LSD_RST_BYTE);
        for (int i = 20; i < 24; i++) chk_rd(5'(i), 8'h00);
        chk_rd(`LSD_ADDR_PART_REV, {`LSD_PART_CODE, `LSD_REV_CODE});
        chk_rd(`LSD_ADDR_VARIANT, {2'h0, `LSD_VARIANT_CODE, 4'h0});
        cmp_bit(irq_pin_oe, 1'b0);
    endtask : t_reset

    task t_regs();
        lsd_host_model_i.wword(`LSD_ADDR_LOW_TH_LSB, 16'ha55a);
        lsd_host_model_i.wword(`LSD_ADDR_HIGH_TH_LSB, 16'h1234);
        point(`LSD_ADDR_LOW_TH_LSB);
        rd_chk(8'h5a);
        rd_chk(8'ha5);
        rd_chk(8'h34);
        rd_chk(8'h12);
        // a lone byte with msb set only moves the pointer
        lsd_host_model_i.start();
        lsd_host_model_i.wr({3'b100, `LSD_ADDR_HIGH_TH_MSB});
        lsd_host_model_i.start();
        rd_chk(8'h12);
        wreg(`LSD_ADDR_CH0_LSB, 8'hff);
        chk_rd(`LSD_ADDR_CH0_LSB, 8'h00);
        wreg(`LSD_ADDR_PART_REV, 8'h00);
        chk_rd(`LSD_ADDR_PART_REV, {`LSD_PART_CODE, `LSD_REV_CODE});
        for (int g = 0; g < 4; g++) begin
            wreg(`LSD_ADDR_ANALOG, 8'(g));
            #1;
            cmp_byte({5'h0, gain_sel}, 8'(g));
        end
    endtask : t_regs

    task t_data();
        conv(16'h1234, 16'hbeef);
        point(`LSD_ADDR_CH0_LSB);
        rd_chk(8'h34);
        rd_chk(8'h12);
        rd_chk(8'hef);
        rd_chk(8'hbe);
        point(`LSD_ADDR_CH0_LSB);
        rd_chk(8'h34);
        conv(16'h5678, 16'h0000);
        rd_chk(8'h12);
        chk_rd(`LSD_ADDR_CH0_LSB, 8'h78);
    endtask : t_data

    task t_irq();
        lsd_host_model_i.wword(`LSD_ADDR_LOW_TH_LSB, 16'h0064);
        lsd_host_model_i.wword(`LSD_ADDR_HIGH_TH_LSB, 16'h00c8);
        wreg(`LSD_ADDR_IRQ_CTRL, 8'h00);
        conv(16'h0005, 16'h0000);
        cmp_bit(irq_pin_oe, 1'b0);
        wreg(`LSD_ADDR_IRQ_CTRL, 8'h10);
        clr();
        conv(16'h0096, 16'h0000);
        cmp_bit(irq_pin_oe, 1'b1);
        cmp_bit(irq_pin_out, 1'b0);
        clr();
        cmp_bit(irq_pin_oe, 1'b0);
        wreg(`LSD_ADDR_IRQ_CTRL, 8'h11);
        conv(16'h0096, 16'h0000);
        cmp_bit(irq_pin_oe, 1'b0);
        conv(16'h0064, 16'h0000);
        cmp_bit(irq_pin_oe, 1'b1);
        clr();
        conv(16'h00c8, 16'h0000);
        cmp_bit(irq_pin_oe, 1'b0);
        conv(16'h00c9, 16'h0000);
        cmp_bit(irq_pin_oe, 1'b1);
        wreg(`LSD_ADDR_IRQ_CTRL, 8'h13);
        clr();
        conv(16'h0096, 16'h0000);
        conv(16'h0032, 16'h0000);
        conv(16'h0032, 16'h0000);
        conv(16'h0096, 16'h0000);
        conv(16'h0032, 16'h0000);
        conv(16'h0032, 16'h0000);
        cmp_bit(irq_pin_oe, 1'b0);
        conv(16'h0032, 16'h0000);
        cmp_bit(irq_pin_oe, 1'b1);
        clr();
    endtask : t_irq

    task t_halt();
        wreg(`LSD_ADDR_IRQ_CTRL, 8'h50);
        conv(16'h0096, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        cmp_bit(adc_halt, 1'b1);
        conv(16'h0032, 16'h0000);
        chk_rd(`LSD_ADDR_CH0_LSB, 8'h96);
        @(posedge clk);
        adc_enable <= 1'b0;
        clr();
        repeat (2) @(posedge clk);
        #1;
        cmp_bit(adc_halt, 1'b0);
        cmp_bit(irq_pin_oe, 1'b0);
        @(posedge clk);
        adc_enable <= 1'b1;
        wreg(`LSD_ADDR_IRQ_CTRL, 8'h00);
    endtask : t_halt

    // run spans three whole steps plus a margin short of a fourth
    task t_timer();
        @(posedge clk);
        manual_run <= 1'b1;
        repeat (`LSD_TIMER_STEP_CYC * 3 + 20) @(posedge clk);
        manual_run <= 1'b0;
        chk_rd(`LSD_ADDR_TIMER_LSB, 8'h03);
        chk_rd(`LSD_ADDR_TIMER_MSB, 8'h00);
    endtask : t_timer

    task end_of_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_data();
        t_irq();
        t_halt();
        t_timer();
        end_of_test();
    end
endmodule : lsd_reg_bank_tb
